// [rtl/clkout_pkg.sv]
// shared constants and types for the bus-clock output pin control block
package clkout_pkg;

    localparam int          ADDR_W             = 4;
    // register word offsets (byte addresses)
    localparam logic [3:0]  OFF_CLK_CTRL       = 4'h0;
    localparam logic [3:0]  OFF_STANDBY_CTRL   = 4'h4;
    localparam logic [3:0]  OFF_MODULE_STOP    = 4'h8;
    localparam logic [3:0]  OFF_WAKE_CTRL      = 4'hC;

    // clock control word fields
    localparam int          CLK_STOP_POS       = 0;
    localparam int          CLK_DIR_POS        = 1;
    localparam int          CLK_HOLD_POS       = 2;
    localparam int          CLK_STATUS_POS     = 8;
    // standby control word fields
    localparam int          STS_LSB_POS        = 0;
    localparam int          STBY_SEL_POS       = 8;
    localparam int          STBY_DRIVE_POS     = 9;
    localparam int          STBY_DEEP_POS      = 10;
    localparam int          STBY_STATE_POS     = 16;
    // module stop word fields
    localparam int          XFER_STOP_POS      = 12;
    localparam int          INT_DMA_STOP_POS   = 13;
    localparam int          EXT_DMA_STOP_POS   = 14;
    // wake control word fields
    localparam int          WAKE_BUF_POS       = 0;
    localparam int          SBY_IRQ_EN_POS     = 8;

    localparam int          N_WAKE             = 4;
    localparam int          N_SBY_IRQ          = 13;

    // reset values
    localparam logic [31:0] CLK_CTRL_RST       = 32'h0000_0002;
    localparam logic [31:0] MSTOP_RST          = 32'h0000_0000;
    localparam logic [4:0]  STS_RST            = 5'h00;
    localparam logic [15:0] SBY_IRQ_EN_RST     = 16'h1FFF;

    // settling time: units of 256 cycles per step of the select field
    localparam int          SETTLE_UNIT_CYC    = 256;
    localparam int          SETTLE_CNT_W       = 14;

    typedef enum logic [2:0] {
        PM_NORMAL     = 3'b000,
        PM_SLEEP      = 3'b001,
        PM_ALLSTOP    = 3'b010,
        PM_SW_STANDBY = 3'b011,
        PM_DEEP_STBY  = 3'b100,
        PM_HW_STANDBY = 3'b101
    } power_mode_type;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_STBY   = 2'b01,
        ST_SETTLE = 2'b10,
        ST_DEEP   = 2'b11
    } stby_state_type;

    // wishbone request bundle
    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [3:0]        sel;
        logic [ADDR_W-1:0] adr;
        logic [31:0]       dat;
    } wb_req_type;

    // two-signal pin drive view, oe low while driving
    typedef struct packed {
        logic o;
        logic oe_n;
    } pin_drive_type;

endpackage : clkout_pkg

// [rtl/clkout_gate.sv]
// glitch-free gate between toggling bus clock and a held-high level
`timescale 1ns/1ps
`default_nettype none
module clkout_gate
    import clkout_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    input  wire logic bus_idle_i,
    output logic      clk_pin_o,
    output logic      running_o
);
    logic phase_q;
    logic phase_d;
    logic run_q;
    logic run_d;

    // pin runs at half the system clock; switching only at the high phase
    // end keeps every high and low pulse full width
    always_comb begin
        phase_d = run_q ? ~phase_q : 1'b1;
        run_d   = run_q;
        if (phase_q && (run_i || bus_idle_i)) begin
            run_d = run_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= 1'b1;
            run_q   <= 1'b0;
        end else begin
            phase_q <= phase_d;
            run_q   <= run_d;
        end
    end

    assign clk_pin_o = phase_q;
    assign running_o = run_q;
endmodule : clkout_gate
`default_nettype wire

// [rtl/clkout_ctrl.sv]
// bus-clock output pin, standby pin control and power-down gating
// Overview of operation
// - stop bit 0 and direction output: bus clock driven on pin
// - stop bit 1: clock stops after current bus cycle, pin held high
// - direction 0: pin high impedance input regardless of stop bit
// - per-mode table: clock, high in standby, hi-z in hardware standby
// - standby modes keep every output port at its prior state; the clock pin here is driven high instead
// - dma and transfer stop bits refused while unit active
// - stopped module masks its interrupt requests
// - wake buffer enable overrides pin input buffer control
// - clearing source during deep entry runs standby clearing instead
// - interrupt exception begins after the selected settling time
// - nmi coinciding with deep entry is taken as exception
// - disabled standby interrupt sources do not block deep standby
// - clock may be undefined one cycle after hold release
// - after deep exit with hold, pins frozen until hold cleared
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module clkout_ctrl
    import clkout_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [ADDR_W-1:0]    adr_i,
    input  wire logic [31:0]          dat_i,
    output logic [31:0]               dat_o,
    output logic                      ack_o,
    input  wire logic                 cpu_master_i,
    // power state
    input  wire logic [2:0]           power_mode_i,
    input  wire logic                 sleep_req_i,
    input  wire logic                 bus_idle_i,
    input  wire logic                 deep_exit_i,
    // standby clearing sources
    input  wire logic                 nmi_i,
    input  wire logic [N_SBY_IRQ-1:0] sby_irq_i,
    output logic                      exc_start_o,
    output logic                      nmi_take_o,
    output logic                      deep_enter_o,
    // module stop
    input  wire logic [2:0]           unit_active_i,
    input  wire logic [2:0]           unit_irq_i,
    output logic [2:0]                unit_stop_o,
    output logic [2:0]                unit_irq_o,
    // wake input buffers
    input  wire logic [N_WAKE-1:0]    wake_pin_i,
    input  wire logic [N_WAKE-1:0]    port_input_buf_ctrl_i,
    output logic [N_WAKE-1:0]         wake_pin_o,
    // clock pin, three-signal form
    input  wire logic                 clkout_port_pin_i,
    output logic                      clkout_port_pin_o,
    output logic                      clkout_port_pin_oe_n_o,
    input  wire logic                 port_dr_i
);
    logic [31:0]   clk_ctrl_q,  clk_ctrl_d;
    logic [31:0]   mstop_q,     mstop_d;
    logic [4:0]    sts_q,       sts_d;
    logic          stby_sel_q,  stby_sel_d;
    logic          drive_en_q,  drive_en_d;
    logic          deep_sel_q,  deep_sel_d;
    logic [N_WAKE-1:0]    wake_buf_q, wake_buf_d;
    logic [N_SBY_IRQ-1:0] sby_en_q,   sby_en_d;
    logic          ack_q,       ack_d;
    logic [31:0]   rdat_q,      rdat_d;
    logic          hold_q,      hold_d;
    pin_drive_type pin_q,       pin_d;
    stby_state_type st_q,       st_d;
    logic [SETTLE_CNT_W-1:0] cnt_q, cnt_d;
    logic          exc_q,       exc_d;
    logic          nmi_q,       nmi_d;
    logic          deep_q,      deep_d;

    logic          gate_clk;
    logic          gate_run;
    logic          stop_bit;
    logic          dir_bit;
    logic          wr;
    logic          rd;
    logic          wake_src;
    logic [2:0]    stop_req;
    power_mode_type pm;

    assign pm       = power_mode_type'(power_mode_i);
    assign stop_bit = clk_ctrl_q[CLK_STOP_POS];
    assign dir_bit  = clk_ctrl_q[CLK_DIR_POS];
    assign wr       = cyc_i && stb_i && we_i && !ack_q;
    assign rd       = cyc_i && stb_i && !we_i && !ack_q;
    // sources whose standby enable is clear do not count
    assign wake_src = |(sby_irq_i & sby_en_q);

    clkout_gate u_gate (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .run_i      (!stop_bit && dir_bit),
        .bus_idle_i (bus_idle_i),
        .clk_pin_o  (gate_clk),
        .running_o  (gate_run)
    );

    // register file
    always_comb begin
        clk_ctrl_d = clk_ctrl_q;
        mstop_d    = mstop_q;
        sts_d      = sts_q;
        stby_sel_d = stby_sel_q;
        drive_en_d = drive_en_q;
        deep_sel_d = deep_sel_q;
        wake_buf_d = wake_buf_q;
        sby_en_d   = sby_en_q;
        hold_d     = hold_q;
        ack_d      = cyc_i && stb_i && !ack_q;
        rdat_d     = rdat_q;
        stop_req   = 3'h0;
        if (deep_exit_i && hold_q) begin
            hold_d = 1'b1;
        end
        if (wr && sel_i[0]) begin
            case (adr_i)
                OFF_CLK_CTRL: begin
                    clk_ctrl_d[CLK_STOP_POS] = dat_i[CLK_STOP_POS];
                    clk_ctrl_d[CLK_DIR_POS]  = dat_i[CLK_DIR_POS];
                    // deep exit wins over a same-cycle write of hold
                    if (!deep_exit_i) begin
                        hold_d = dat_i[CLK_HOLD_POS];
                    end
                end
                OFF_STANDBY_CTRL: begin
                    sts_d = dat_i[STS_LSB_POS +: 5];
                end
                OFF_WAKE_CTRL: begin
                    wake_buf_d = dat_i[WAKE_BUF_POS +: N_WAKE];
                end
                default: begin
                end
            endcase
        end
        if (wr && sel_i[1]) begin
            case (adr_i)
                OFF_STANDBY_CTRL: begin
                    stby_sel_d = dat_i[STBY_SEL_POS];
                    drive_en_d = dat_i[STBY_DRIVE_POS];
                    deep_sel_d = dat_i[STBY_DEEP_POS];
                end
                OFF_MODULE_STOP: begin
                    // only cpu writes land here
                    if (cpu_master_i) begin
                        stop_req = dat_i[XFER_STOP_POS +: 3];
                        for (int i = 0; i < 3; i++) begin
                            // active units refuse to be stopped
                            if (!(stop_req[i] && unit_active_i[i])) begin
                                mstop_d[XFER_STOP_POS + i] = stop_req[i];
                            end
                        end
                    end
                end
                OFF_WAKE_CTRL: begin
                    sby_en_d[7:0] = dat_i[SBY_IRQ_EN_POS +: 8];
                end
                default: begin
                end
            endcase
        end
        if (wr && sel_i[2] && adr_i == OFF_WAKE_CTRL) begin
            sby_en_d[N_SBY_IRQ-1:8] = dat_i[SBY_IRQ_EN_POS + 8 +: 5];
        end
        if (rd) begin
            case (adr_i)
                OFF_CLK_CTRL: rdat_d = {23'h0, gate_run, 5'h0, hold_q,
                                        dir_bit, stop_bit};
                OFF_STANDBY_CTRL: rdat_d = {14'h0, st_q, 5'h0, deep_sel_q,
                                            drive_en_q, stby_sel_q,
                                            3'h0, sts_q};
                OFF_MODULE_STOP: rdat_d = mstop_q;
                OFF_WAKE_CTRL: rdat_d = {11'h0, sby_en_q, 4'h0, wake_buf_q};
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_ctrl_q <= CLK_CTRL_RST;
            mstop_q    <= MSTOP_RST;
            sts_q      <= STS_RST;
            stby_sel_q <= 1'b0;
            drive_en_q <= 1'b0;
            deep_sel_q <= 1'b0;
            wake_buf_q <= '0;
            sby_en_q   <= SBY_IRQ_EN_RST[N_SBY_IRQ-1:0];
            hold_q     <= 1'b0;
            ack_q      <= 1'b0;
            rdat_q     <= 32'h0000_0000;
        end else begin
            clk_ctrl_q <= clk_ctrl_d;
            mstop_q    <= mstop_d;
            sts_q      <= sts_d;
            stby_sel_q <= stby_sel_d;
            drive_en_q <= drive_en_d;
            deep_sel_q <= deep_sel_d;
            wake_buf_q <= wake_buf_d;
            sby_en_q   <= sby_en_d;
            hold_q     <= hold_d;
            ack_q      <= ack_d;
            rdat_q     <= rdat_d;
        end
    end

    // standby entry, clearing and settle sequencer
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        exc_d  = 1'b0;
        nmi_d  = 1'b0;
        deep_d = 1'b0;
        case (st_q)
            ST_RUN: begin
                if (sleep_req_i && stby_sel_q) begin
                    if (deep_sel_q && nmi_i) begin
                        nmi_d = 1'b1;
                    end else if (deep_sel_q && wake_src) begin
                        // abandon deep entry, clear as for standby
                        st_d  = ST_SETTLE;
                        cnt_d = SETTLE_CNT_W'(sts_q) * SETTLE_CNT_W'(SETTLE_UNIT_CYC);
                    end else if (deep_sel_q) begin
                        st_d   = ST_DEEP;
                        deep_d = 1'b1;
                    end else begin
                        st_d = ST_STBY;
                    end
                end
            end
            ST_STBY: begin
                if (wake_src || nmi_i) begin
                    st_d  = ST_SETTLE;
                    cnt_d = SETTLE_CNT_W'(sts_q) * SETTLE_CNT_W'(SETTLE_UNIT_CYC);
                end
            end
            ST_SETTLE: begin
                if (cnt_q == '0) begin
                    exc_d = 1'b1;
                    st_d  = ST_RUN;
                end else begin
                    cnt_d = cnt_q - SETTLE_CNT_W'(1);
                end
            end
            ST_DEEP: begin
                if (deep_exit_i) begin
                    st_d = ST_RUN;
                end
            end
            default: st_d = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q   <= ST_RUN;
            cnt_q  <= '0;
            exc_q  <= 1'b0;
            nmi_q  <= 1'b0;
            deep_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            exc_q  <= exc_d;
            nmi_q  <= nmi_d;
            deep_q <= deep_d;
        end
    end

    // pin driver, registered so no decode glitch reaches the pad
    always_comb begin
        pin_d = pin_q;
        if (pm == PM_HW_STANDBY || !dir_bit) begin
            pin_d.o    = 1'b1;
            pin_d.oe_n = 1'b1;
        end else if (pm == PM_SW_STANDBY || pm == PM_DEEP_STBY) begin
            // pin stays driven high; load current keeps flowing
            pin_d.o    = 1'b1;
            pin_d.oe_n = 1'b0;
        end else if (hold_q) begin
            pin_d = pin_q;
        end else begin
            // gate output lands one cycle late; at most one odd cycle
            pin_d.o    = gate_clk;
            pin_d.oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_q <= '{o: 1'b1, oe_n: 1'b1};
        end else begin
            pin_q <= pin_d;
        end
    end

    // wake pins bypass the port input buffer control when enabled
    genvar g;
    generate
        for (g = 0; g < N_WAKE; g++) begin : g_wake
            assign wake_pin_o[g] = (wake_buf_q[g] || port_input_buf_ctrl_i[g])
                                   ? wake_pin_i[g] : 1'b0;
        end
    endgenerate

    assign unit_stop_o = mstop_q[XFER_STOP_POS +: 3];
    assign unit_irq_o  = unit_irq_i & ~unit_stop_o;
    assign clkout_port_pin_o      = pin_q.o;
    assign clkout_port_pin_oe_n_o = pin_q.oe_n;
    assign dat_o        = rdat_q;
    assign ack_o        = ack_q;
    assign exc_start_o  = exc_q;
    assign nmi_take_o   = nmi_q;
    assign deep_enter_o = deep_q;
endmodule : clkout_ctrl
`default_nettype wire

// [test/clkout_ctrl_assertions.sv]
// concurrent checks on the ports of the bus-clock pin control block
`timescale 1ns/1ps
`default_nettype none
module clkout_ctrl_checker
    import clkout_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire logic [2:0] power_mode_i,
    input wire logic       bus_idle_i,
    input wire logic       cpu_master_i,
    input wire logic [2:0] unit_active_i,
    input wire logic [2:0] unit_irq_i,
    input wire logic [2:0] unit_stop_o,
    input wire logic [2:0] unit_irq_o,
    input wire logic       exc_start_o,
    input wire logic       nmi_take_o,
    input wire logic       deep_enter_o,
    input wire logic       clkout_port_pin_o,
    input wire logic       clkout_port_pin_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ack_delay_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing one cycle after request");
    hwstby_hiz_a: assert property ((power_mode_i == PM_HW_STANDBY)[*2]
        |-> clkout_port_pin_oe_n_o) else $error("pin driven in hw standby");
    stby_high_a: assert property ((power_mode_i == PM_SW_STANDBY ||
        power_mode_i == PM_DEEP_STBY)[*4] ##0 !clkout_port_pin_oe_n_o
        |-> clkout_port_pin_o) else $error("pin not high in standby");
    irq_gate_a: assert property (unit_irq_o == (unit_irq_i & ~unit_stop_o))
        else $error("stopped unit passes its request");
    stop_refuse_a: assert property ((unit_stop_o & ~$past(unit_stop_o)
        & $past(unit_active_i)) == 3'h0) else $error("active unit stopped");
    stop_cpu_a: assert property (|(unit_stop_o & ~$past(unit_stop_o))
        |-> $past(cpu_master_i)) else $error("stop set by non cpu master");
    one_event_a: assert property ($onehot0({exc_start_o, nmi_take_o,
        deep_enter_o})) else $error("conflicting standby outcomes");
    clk_busy_a: assert property ((!bus_idle_i &&
        power_mode_i == PM_NORMAL)[*4] ##0 ($rose(clkout_port_pin_o)
        && !clkout_port_pin_oe_n_o) |=> !clkout_port_pin_o)
        else $error("clock stopped inside a bus cycle");

    cover property (exc_start_o);
    cover property (deep_enter_o);
    cover property (nmi_take_o);
    cover property (|unit_stop_o);
endmodule : clkout_ctrl_checker

bind clkout_ctrl clkout_ctrl_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i,
    .ack_o, .power_mode_i, .bus_idle_i, .cpu_master_i, .unit_active_i,
    .unit_irq_i, .unit_stop_o, .unit_irq_o, .exc_start_o, .nmi_take_o,
    .deep_enter_o, .clkout_port_pin_o, .clkout_port_pin_oe_n_o);
`default_nettype wire

// [test/bus_clk_sink.sv]
// external device fed by the bus clock pin
`timescale 1ns/1ps
`default_nettype none
module bus_clk_sink (
    input  wire logic clk_i,
    input  wire logic pin_i,
    input  wire logic oe_n_i,
    output logic      wire_o,
    output int        n_clk_o,
    output int        n_any_o
);
    logic last_q = 1'b1;
    logic prev_q = 1'b1;
    // released wire shows the inverse so a stale level cannot pass
    assign wire_o = oe_n_i ? ~last_q : pin_i;
    initial n_clk_o = 0;
    initial n_any_o = 0;
    always @(posedge clk_i) begin
        if (!oe_n_i) last_q <= pin_i;
        if (!oe_n_i && wire_o && !prev_q) n_clk_o <= n_clk_o + 1;
        prev_q <= wire_o;
    end
    // any-time edges exceed sampled edges only on a runt pulse
    always @(posedge wire_o) begin
        if (!oe_n_i) n_any_o <= n_any_o + 1;
    end
endmodule : bus_clk_sink
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the bus-clock pin control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import clkout_pkg::*;
    logic                 clk_i = 1'b0, rst_i = 1'b1;
    logic                 cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0]           sel_i = 4'hF, adr_i = 4'h0;
    logic [31:0]          dat_i = 32'h0, dat_o, rd;
    logic                 ack_o, cpu_master_i = 1'b1, sleep_req_i = 1'b0;
    logic                 bus_idle_i = 1'b1, deep_exit_i = 1'b0, nmi_i = 1'b0;
    logic [2:0]           power_mode_i = 3'h0, unit_active_i = 3'h0;
    logic [2:0]           unit_irq_i = 3'h0, unit_stop_o, unit_irq_o;
    logic [N_SBY_IRQ-1:0] sby_irq_i = {N_SBY_IRQ{1'b0}};
    logic                 exc_start_o, nmi_take_o, deep_enter_o;
    logic [3:0]           wake_pin_i = 4'h0, port_input_buf_ctrl_i = 4'h0;
    logic [3:0]           wake_pin_o;
    logic                 clkout_port_pin_i, clkout_port_pin_o;
    logic                 clkout_port_pin_oe_n_o;
    int                   fails = 0, n_tests = 0, n_clk, n_any;

    always #12.5 clk_i = ~clk_i;

    clkout_ctrl dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i,
        .dat_i, .dat_o, .ack_o, .cpu_master_i, .power_mode_i, .sleep_req_i,
        .bus_idle_i, .deep_exit_i, .nmi_i, .sby_irq_i, .exc_start_o,
        .nmi_take_o, .deep_enter_o, .unit_active_i, .unit_irq_i, .unit_stop_o,
        .unit_irq_o, .wake_pin_i, .port_input_buf_ctrl_i, .wake_pin_o,
        .clkout_port_pin_i, .clkout_port_pin_o, .clkout_port_pin_oe_n_o,
        .port_dr_i(1'b0));
    bus_clk_sink sink_u (.clk_i, .pin_i(clkout_port_pin_o),
        .oe_n_i(clkout_port_pin_oe_n_o), .wire_o(clkout_port_pin_i),
        .n_clk_o(n_clk), .n_any_o(n_any));

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic end_sim;
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin fails++; end_sim(); end
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask : wb

    task automatic meas(input string nm, input int c, input int e);
        int k0, a0;
        @(negedge clk_i);
        k0 = n_clk; a0 = n_any;
        repeat (c) @(negedge clk_i);
        chk(nm, e, n_clk - k0);
        chk("runt pulse", n_clk - k0, n_any - a0);
    endtask : meas

    task automatic fire(input logic n, input logic [2:0] e, input int lo, hi);
        int c;
        logic [2:0] s;
        @(posedge clk_i);
        sleep_req_i <= 1'b1; nmi_i <= n; sby_irq_i[0] <= ~n;
        // one-cycle request so a finished settle does not re-enter
        @(posedge clk_i);
        sleep_req_i <= 1'b0; nmi_i <= 1'b0; sby_irq_i[0] <= 1'b0;
        c = 0;
        do begin
            @(posedge clk_i); c++;
            s = {exc_start_o, nmi_take_o, deep_enter_o};
        end while (s == 3'h0 && c < 400);
        chk("outcome", e, s);
        chk("delay", 1, c >= lo && c <= hi);
    endtask : fire

    task automatic t_regs;
        wb(0, OFF_CLK_CTRL, 0); chk("clk ctrl", CLK_CTRL_RST & 7, rd & 7);
        wb(0, OFF_WAKE_CTRL, 0); chk("sby en", 32'h1FFF, (rd >> 8) & 32'h1FFF);
        wb(1, 4'h2, 32'hFFFF_FFFF); wb(0, 4'h2, 0); chk("unmapped", 0, rd);
    endtask : t_regs

    task automatic t_stop;
        meas("running", 20, 10);
        @(posedge clk_i); bus_idle_i <= 1'b0;
        wb(1, OFF_CLK_CTRL, 32'h3); meas("busy", 10, 5);
        @(posedge clk_i); bus_idle_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        meas("stopped", 10, 0); chk("held", 1, clkout_port_pin_o);
        wb(1, OFF_CLK_CTRL, 32'h2); repeat (4) @(posedge clk_i);
        meas("restart", 10, 5);
        wb(1, OFF_CLK_CTRL, 32'h6); meas("frozen", 10, 0);
        wb(0, OFF_CLK_CTRL, 0); chk("hold", 32'h4, rd & 32'h4);
        wb(1, OFF_CLK_CTRL, 32'h2); repeat (4) @(posedge clk_i);
    endtask : t_stop

    task automatic t_dir;
        for (int v = 0; v < 2; v++) begin
            wb(1, OFF_CLK_CTRL, v); repeat (4) @(negedge clk_i);
            chk("dir hiz", 1, clkout_port_pin_oe_n_o);
        end
        wb(1, OFF_CLK_CTRL, 32'h2);
    endtask : t_dir

    task automatic t_modes;
        for (int m = 0; m < 6; m++) begin
            @(posedge clk_i); power_mode_i <= 3'(m);
            repeat (6) @(posedge clk_i);
            if (m < 5) meas("mode clk", 8, (m < 3) ? 4 : 0);
            @(negedge clk_i);
            chk("mode oe", m == 5, clkout_port_pin_oe_n_o);
            if (m == 3 || m == 4) chk("mode hi", 1, clkout_port_pin_o);
        end
        @(posedge clk_i); power_mode_i <= PM_NORMAL;
    endtask : t_modes

    task automatic t_mstop;
        @(posedge clk_i); unit_active_i <= 3'h1; unit_irq_i <= 3'h7;
        wb(1, OFF_MODULE_STOP, 32'h7000); wb(0, OFF_MODULE_STOP, 0);
        chk("mstop", 32'h6000, rd & 32'h7000);
        @(negedge clk_i); chk("irq gate", 3'h1, unit_irq_o);
        @(posedge clk_i); cpu_master_i <= 1'b0;
        wb(1, OFF_MODULE_STOP, 0); wb(0, OFF_MODULE_STOP, 0);
        chk("non cpu", 32'h6000, rd & 32'h7000);
        @(posedge clk_i); cpu_master_i <= 1'b1; unit_active_i <= 3'h0;
        wb(1, OFF_MODULE_STOP, 0);
    endtask : t_mstop

    task automatic t_wake;
        wb(1, OFF_WAKE_CTRL, 32'h001F_FF05);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            wake_pin_i <= {4{i[0]}}; port_input_buf_ctrl_i <= {4{i[1]}};
            @(negedge clk_i);
            chk("wake", {4{i[0]}} & 4'h5, wake_pin_o & 4'h5);
        end
    endtask : t_wake

    task automatic t_deep;
        wb(1, OFF_STANDBY_CTRL, 32'h0000_0501);
        fire(0, 3'b100, SETTLE_UNIT_CYC, SETTLE_UNIT_CYC + 14);
        wb(1, OFF_WAKE_CTRL, 0);
        fire(0, 3'b001, 1, 20);
        @(posedge clk_i); deep_exit_i <= 1'b1;
        @(posedge clk_i); deep_exit_i <= 1'b0;
        fire(1, 3'b010, 1, 20);
    endtask : t_deep

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_regs(); t_stop(); t_dir(); t_modes();
        t_mstop(); t_wake(); t_deep();
        end_sim();
    end
endmodule : tb
`default_nettype wire
